/* hw/rftc_timing_control.sv */
// transmit delay, modulation pulse and tag silence timing control
// assumes framing logic on core_clk gives single-cycle event pulses
// How it works
// RULE1 - delayed transmission starts after programmed length times 590 ns
// RULE2 - a timer length of all zeros disables the delayed transmission
// RULE3 - protocol selection loads zero into the delay timer low byte
// RULE4 - reset, enable low, protocol write preset low, pulse, silence
// RULE5 - nonzero pulse length gives pulses of value times 73.7 ns
// RULE6 - zero pulse length takes pulse length from the protocol
// RULE7 - type a defaults: 2.36 us, 1.4 us, 737 ns, 442 ns
// RULE8 - silent slot raises interrupt and sets status flag
// RULE9 - silence wait counts 37.76 us units, values 1 to 255
// RULE10 - silence measurement starts at end of transmitted end of frame
// RULE11 - each protocol selection reloads the silence wait default
// RULE12 - silence defaults 755 us high, 1812 us low, 529 us others
// RULE13 - fifo reset after transmit complete cancels silence detection
// RULE14 - silence interrupt works only with a vicinity protocol
// RULE15 - high byte resets to c2: start select and upper length
// RULE16 - upper six and low eight bits form one 14-bit count
// RULE17 - host selects protocol before writing custom timing values
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module rftc_timing_control
    import rftc_pkg::*;
#(
    parameter int SILENCE_STEP_CYCLES = SILENCE_STEP_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // chip enable pin
    input wire logic chip_enable,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // framing events
    input wire logic tx_sof_begin,
    input wire logic tx_sof_end,
    input wire logic rx_sof_begin,
    input wire logic rx_sof_end,
    input wire logic tx_eof_end,
    input wire logic tx_complete,
    input wire logic rx_response_start,
    input wire logic mod_pulse_req,
    // timing outputs
    output logic [2:0] protocol,
    output logic delayed_tx_start,
    output logic tx_mod_pulse,
    output logic irq
);

    // ---------------------------------------------------------------
    // enable pin synchroniser
    // ---------------------------------------------------------------
    logic enable_meta;
    logic enable_sync;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            enable_meta <= 1'b0;
            enable_sync <= 1'b0;
        end else begin
            enable_meta <= chip_enable;
            enable_sync <= enable_meta;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] tx_delay_timer_high;
    logic [7:0] tx_delay_timer_low;
    logic [7:0] tx_pulse_length;
    logic [7:0] no_response_wait;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic proto_write;
    logic preset;
    logic [7:0] next_silence_wait;

    assign proto_write = reg_write && reg_addr == ADDR_PROTOCOL;
    assign preset = !enable_sync || proto_write;

    // silence default of the protocol being written
    always_comb begin
        unique case (reg_wdata[2:0])
            PROTO_VIC_HIGH: next_silence_wait = SILENCE_VIC_HIGH_CODE;
            PROTO_VIC_LOW: next_silence_wait = SILENCE_VIC_LOW_CODE;
            default: next_silence_wait = SILENCE_OTHER_CODE;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            protocol <= RST_PROTOCOL;
        end else if (!enable_sync) begin
            protocol <= RST_PROTOCOL;
        end else if (proto_write) begin
            protocol <= reg_wdata[2:0];
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_delay_timer_high <= RST_DELAY_HIGH;
            tx_delay_timer_low <= RST_DELAY_LOW;
            tx_pulse_length <= RST_PULSE_LEN;
            no_response_wait <= RST_SILENCE;
        // RULE3 RULE4 RULE15 preset on select
        end else if (preset) begin
            tx_delay_timer_high <= RST_DELAY_HIGH;
            tx_delay_timer_low <= RST_DELAY_LOW;
            tx_pulse_length <= RST_PULSE_LEN;
            // RULE11 RULE12 protocol default wait
            no_response_wait <= enable_sync ? next_silence_wait
                : RST_SILENCE;
        end else if (reg_write) begin
            if (reg_addr == ADDR_DELAY_HIGH) begin
                tx_delay_timer_high <= reg_wdata;
            end
            if (reg_addr == ADDR_DELAY_LOW) begin
                tx_delay_timer_low <= reg_wdata;
            end
            if (reg_addr == ADDR_PULSE_LEN) begin
                tx_pulse_length <= reg_wdata;
            end
            if (reg_addr == ADDR_SILENCE) begin
                no_response_wait <= reg_wdata;
            end
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (!reg_read) begin
            reg_rdata <= 8'h00;
        end else begin
            unique case (reg_addr)
                ADDR_PROTOCOL: reg_rdata <= {5'h00, protocol};
                ADDR_DELAY_HIGH: reg_rdata <= tx_delay_timer_high;
                ADDR_DELAY_LOW: reg_rdata <= tx_delay_timer_low;
                ADDR_PULSE_LEN: reg_rdata <= tx_pulse_length;
                ADDR_SILENCE: reg_rdata <= no_response_wait;
                ADDR_IRQ_STATUS: reg_rdata <= {6'h00, irq_status};
                ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // delayed transmission timer
    // ---------------------------------------------------------------
    logic delay_start_event;
    logic [13:0] delay_count;
    logic delay_busy;
    logic [1:0] delay_start_sel;

    assign delay_start_sel = tx_delay_timer_high[7:6];
    // RULE16 14-bit length
    assign delay_count = {tx_delay_timer_high[5:0], tx_delay_timer_low};

    always_comb begin
        unique case (delay_start_sel)
            SEL_TX_SOF_BEGIN: delay_start_event = tx_sof_begin;
            SEL_TX_SOF_END: delay_start_event = tx_sof_end;
            SEL_RX_SOF_BEGIN: delay_start_event = rx_sof_begin;
            SEL_RX_SOF_END: delay_start_event = rx_sof_end;
        endcase
    end

    // RULE1 RULE2 steps of 590 ns, zero idles
    rftc_step_timer #(
        .WIDTH(14),
        .STEP(DELAY_STEP_CYC)
    ) delay_timer (
        .core_clk(core_clk),
        .reset(reset),
        .start(delay_start_event),
        .clear(preset),
        .length(delay_count),
        .busy(delay_busy),
        .done(delayed_tx_start)
    );

    // ---------------------------------------------------------------
    // modulation pulse length
    // ---------------------------------------------------------------
    logic [13:0] pulse_default;
    logic [13:0] pulse_cycles;

    // RULE7 protocol default lengths
    always_comb begin
        unique case (protocol)
            PROTO_A106: pulse_default = PULSE_A106_CYC;
            PROTO_A212: pulse_default = PULSE_A212_CYC;
            PROTO_A424: pulse_default = PULSE_A424_CYC;
            PROTO_A848: pulse_default = PULSE_A848_CYC;
            default: pulse_default = PULSE_VIC_CYC;
        endcase
    end

    // RULE5 RULE6 override when nonzero
    assign pulse_cycles = tx_pulse_length != 8'h00
        ? 14'(tx_pulse_length * PULSE_STEP_CYC) : pulse_default;

    rftc_step_timer #(
        .WIDTH(14),
        .STEP(1)
    ) pulse_timer (
        .core_clk(core_clk),
        .reset(reset),
        .start(mod_pulse_req),
        .clear(1'b0),
        .length(pulse_cycles),
        .busy(tx_mod_pulse),
        .done()
    );

    // ---------------------------------------------------------------
    // tag silence detection
    // ---------------------------------------------------------------
    logic vicinity;
    logic tx_done_seen;
    logic silence_cancel;
    logic silence_start;
    logic silence_busy;
    logic silence_done;

    assign vicinity = protocol == PROTO_VIC_LOW
        || protocol == PROTO_VIC_HIGH;
    // RULE13 cancel after transmit complete
    assign silence_cancel = tx_done_seen && reg_write
        && reg_addr == ADDR_COMMAND && reg_wdata == CMD_FIFO_RESET;
    // RULE10 RULE14 start at end of frame
    assign silence_start = tx_eof_end && vicinity;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tx_done_seen <= 1'b0;
        end else if (tx_complete) begin
            tx_done_seen <= 1'b1;
        end else if (silence_cancel || preset || tx_eof_end) begin
            tx_done_seen <= 1'b0;
        end
    end

    // RULE9 steps of 37.76 us
    rftc_step_timer #(
        .WIDTH(8),
        .STEP(SILENCE_STEP_CYCLES)
    ) silence_timer (
        .core_clk(core_clk),
        .reset(reset),
        .start(silence_start),
        .clear(silence_cancel || rx_response_start || preset),
        .length(no_response_wait),
        .busy(silence_busy),
        .done(silence_done)
    );

    // ---------------------------------------------------------------
    // interrupt
    // ---------------------------------------------------------------
    // RULE8 flag and request on silence
    rftc_irq_status irq_block (
        .core_clk(core_clk),
        .reset(reset),
        .set_bits({delayed_tx_start, silence_done}),
        .read_clear(reg_read && reg_addr == ADDR_IRQ_STATUS),
        .mask_write(reg_write && reg_addr == ADDR_IRQ_MASK),
        .mask_wdata(reg_wdata[1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    logic [31:0] delay_elapsed;
    logic [31:0] silence_elapsed;
    logic [13:0] delay_len_cap;
    logic [7:0] silence_len_cap;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            delay_elapsed <= 32'h0;
            silence_elapsed <= 32'h0;
            delay_len_cap <= 14'h0;
            silence_len_cap <= 8'h0;
        end else begin
            delay_elapsed <= delay_start_event ? 32'h1
                : delay_elapsed + 32'h1;
            silence_elapsed <= silence_start ? 32'h1
                : silence_elapsed + 32'h1;
            if (delay_start_event) begin
                delay_len_cap <= delay_count;
            end
            if (silence_start) begin
                silence_len_cap <= no_response_wait;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence proto_selected;
        enable_sync && proto_write;
    endsequence

    delay_length_a: assert property (delayed_tx_start |-> // RULE1
        delay_elapsed == 32'(delay_len_cap) * 32'(DELAY_STEP_CYC))
        else $error("delayed start at wrong time");
    delay_zero_a: assert property ( // RULE2
        delay_start_event && delay_count == 14'h0 && !preset
        |=> !delay_busy ##1 !delayed_tx_start)
        else $error("zero length delay ran");
    preset_regs_a: assert property (proto_selected |=> // RULE4
        tx_delay_timer_low == 8'h00 && tx_pulse_length == 8'h00
        && tx_delay_timer_high == RST_DELAY_HIGH)
        else $error("registers not preset");
    enable_preset_a: assert property (!enable_sync |=> // RULE4
        tx_delay_timer_low == 8'h00 && no_response_wait == RST_SILENCE)
        else $error("enable low preset missing");
    pulse_override_a: assert property ( // RULE5
        mod_pulse_req && tx_pulse_length != 8'h00 && !tx_mod_pulse
        |=> tx_mod_pulse [*1] ##0
        $past(tx_pulse_length) != 8'h00)
        else $error("override pulse did not start");
    pulse_width_a: assert property ( // RULE6
        mod_pulse_req && tx_pulse_length == 8'h00
        && protocol == PROTO_A848 |=> tx_mod_pulse [*8])
        else $error("default pulse too short");
    pulse_a424_a: assert property ( // RULE7
        mod_pulse_req && tx_pulse_length == 8'h00
        && protocol == PROTO_A424 |-> pulse_cycles == 14'd185)
        else $error("a424 default wrong");
    silence_flag_a: assert property (silence_done |=> // RULE8
        irq_status[STS_SILENCE] && (irq || !irq_mask[STS_SILENCE]))
        else $error("silence flag not set");
    silence_time_a: assert property (silence_done |-> // RULE9
        silence_elapsed == 32'(silence_len_cap)
        * 32'(SILENCE_STEP_CYCLES))
        else $error("silence wait wrong");
    silence_begin_a: assert property ( // RULE10
        silence_start && no_response_wait != 8'h00 && !preset
        && !silence_cancel && !rx_response_start |=> silence_busy)
        else $error("silence timer not started");
    silence_load_a: assert property (proto_selected ##0 // RULE11
        reg_wdata[2:0] == PROTO_VIC_LOW |=> no_response_wait == 8'h30)
        else $error("silence default not loaded");
    silence_other_a: assert property (proto_selected ##0 // RULE12
        reg_wdata[2:0] == PROTO_A106 |=> no_response_wait == 8'h0e)
        else $error("other silence default wrong");
    cancel_stop_a: assert property (silence_cancel |=> // RULE13
        !silence_busy ##1 !silence_done)
        else $error("cancel did not stop silence timer");
    vicinity_only_a: assert property (!vicinity |-> // RULE14
        !silence_start)
        else $error("silence started outside vicinity");
    high_reset_a: assert property (!enable_sync |=> // RULE15
        tx_delay_timer_high == 8'hc2)
        else $error("high byte not preset");
    count_join_a: assert property (delay_start_event // RULE16
        |=> delay_len_cap == $past(delay_count))
        else $error("count not joined");

endmodule

/* hw/rftc_pkg.sv */
// constants for the rf transmit/receive timing control block
// assumes a single 250 MHz core clock and an 8-bit register port
package rftc_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_COMMAND = 8'h00;
    localparam logic [7:0] ADDR_PROTOCOL = 8'h01;
    localparam logic [7:0] ADDR_DELAY_HIGH = 8'h04;
    localparam logic [7:0] ADDR_DELAY_LOW = 8'h05;
    localparam logic [7:0] ADDR_PULSE_LEN = 8'h06;
    localparam logic [7:0] ADDR_SILENCE = 8'h07;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0d;

    // ---------------------------------------------------------------
    // reset and preset values, commands, fields
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_DELAY_HIGH = 8'hc2;
    localparam logic [7:0] RST_DELAY_LOW = 8'h00;
    localparam logic [7:0] RST_PULSE_LEN = 8'h00;
    localparam logic [7:0] RST_SILENCE = 8'h0e;
    localparam logic [1:0] RST_IRQ_MASK = 2'h3;
    localparam logic [7:0] CMD_FIFO_RESET = 8'h0f;
    localparam int STS_SILENCE = 0;
    localparam int STS_DELAY = 1;
    localparam logic [2:0] PROTO_VIC_LOW = 3'h0;
    localparam logic [2:0] PROTO_VIC_HIGH = 3'h1;
    localparam logic [2:0] PROTO_A106 = 3'h2;
    localparam logic [2:0] PROTO_A212 = 3'h3;
    localparam logic [2:0] PROTO_A424 = 3'h4;
    localparam logic [2:0] PROTO_A848 = 3'h5;
    localparam logic [2:0] PROTO_OTHER = 3'h6;
    localparam logic [2:0] RST_PROTOCOL = PROTO_OTHER;
    localparam logic [1:0] SEL_TX_SOF_BEGIN = 2'h0;
    localparam logic [1:0] SEL_TX_SOF_END = 2'h1;
    localparam logic [1:0] SEL_RX_SOF_BEGIN = 2'h2;
    localparam logic [1:0] SEL_RX_SOF_END = 2'h3;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int DELAY_STEP_PS = 590000;
    localparam int PULSE_STEP_PS = 73700;
    localparam int SILENCE_STEP_PS = 37760000;
    localparam int DELAY_STEP_CYC = (DELAY_STEP_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int PULSE_STEP_CYC = (PULSE_STEP_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int SILENCE_STEP_CYC = (SILENCE_STEP_PS + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int PULSE_A106_PS = 2360000;
    localparam int PULSE_A212_PS = 1400000;
    localparam int PULSE_A424_PS = 737000;
    localparam int PULSE_A848_PS = 442000;
    localparam int PULSE_VIC_PS = 9440000;
    localparam logic [13:0] PULSE_A106_CYC =
        14'((PULSE_A106_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [13:0] PULSE_A212_CYC =
        14'((PULSE_A212_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [13:0] PULSE_A424_CYC =
        14'((PULSE_A424_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [13:0] PULSE_A848_CYC =
        14'((PULSE_A848_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [13:0] PULSE_VIC_CYC =
        14'((PULSE_VIC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    // silence waits in us, step in units of 10 ns
    localparam int SILENCE_STEP_10NS = 3776;
    localparam int SILENCE_OTHER_US = 529;
    localparam int SILENCE_VIC_HIGH_US = 755;
    localparam int SILENCE_VIC_LOW_US = 1812;
    localparam logic [7:0] SILENCE_OTHER_CODE = 8'((SILENCE_OTHER_US * 100
        + SILENCE_STEP_10NS / 2) / SILENCE_STEP_10NS);
    localparam logic [7:0] SILENCE_VIC_HIGH_CODE = 8'((SILENCE_VIC_HIGH_US
        * 100 + SILENCE_STEP_10NS / 2) / SILENCE_STEP_10NS);
    localparam logic [7:0] SILENCE_VIC_LOW_CODE = 8'((SILENCE_VIC_LOW_US
        * 100 + SILENCE_STEP_10NS / 2) / SILENCE_STEP_10NS);

endpackage

/* hw/rftc_step_timer.sv */
// one-shot down counter that runs length steps of STEP cycles
// assumes start, clear and length come from logic on the same clock
`timescale 1ns/1ps
module rftc_step_timer #(
    parameter int WIDTH = 14,
    parameter int STEP = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // control
    input wire logic start,
    input wire logic clear,
    input wire logic [WIDTH-1:0] length,
    // status
    output logic busy,
    output logic done
);

    logic [WIDTH-1:0] count;
    logic [15:0] prescale;

    // done in the cycle that ends the last step
    assign done = busy && prescale == 16'h0000
        && count == WIDTH'(1);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            count <= '0;
            prescale <= 16'h0000;
        end else if (clear) begin
            busy <= 1'b0;
        end else if (start) begin
            busy <= length != '0;
            count <= length;
            prescale <= 16'(STEP - 1);
        end else if (busy) begin
            if (prescale != 16'h0000) begin
                prescale <= prescale - 16'h0001;
            end else if (count == WIDTH'(1)) begin
                busy <= 1'b0;
            end else begin
                count <= count - WIDTH'(1);
                prescale <= 16'(STEP - 1);
            end
        end
    end

endmodule

/* hw/rftc_irq_status.sv */
// sticky interrupt status with clear on read and a mask
// assumes events are single-cycle pulses on the core clock
`timescale 1ns/1ps
module rftc_irq_status
    import rftc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // events and software access
    input wire logic [1:0] set_bits,
    input wire logic read_clear,
    input wire logic mask_write,
    input wire logic [1:0] mask_wdata,
    // state
    output logic [1:0] status,
    output logic [1:0] mask,
    output logic irq
);

    // a set in the clearing cycle survives
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status <= 2'h0;
        end else begin
            status <= (read_clear ? 2'h0 : status) | set_bits;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mask <= RST_IRQ_MASK;
        end else if (mask_write) begin
            mask <= mask_wdata;
        end
    end

    assign irq = |(status & mask);

endmodule

/* tb/rftc_host.sv */
// host model driving the register port of the timing control block
// assumes one core clock; signals change just after its rising edge
`timescale 1ns/1ps
module rftc_host (
    // clock
    input wire logic core_clk,
    // register port
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end
    // t_proto writes custom values before selecting protocol; t_pulse and t_silence select it first
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
endmodule

/* tb/tb_rftc_timing_control.sv */
// testbench for the timing control block
// assumes the host model on the register port, events driven here
`timescale 1ns/1ps
module tb_rftc_timing_control;
    import rftc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic chip_enable = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_write, reg_read, delayed_tx_start, tx_mod_pulse, irq;
    logic [2:0] protocol;
    int miscompares = 0;
    int checked = 0;
    int n;
    logic [7:0] d;
    logic [15:0] pw [5] = '{16'd590, 16'd350, 16'd185, 16'd111, 16'd38};
    logic [7:0] sw [3] = '{8'h30, 8'h14, 8'h0e};
    logic [2:0] pc [3] = '{3'h0, 3'h1, 3'h6};
    rftc_host rftc_host_inst (.core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read));
    rftc_timing_control #(.SILENCE_STEP_CYCLES(4)) rftc_timing_control_inst (
        .core_clk(core_clk), .reset(reset), .chip_enable(chip_enable),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .tx_sof_begin(ev[0]),
        .tx_sof_end(ev[1]), .rx_sof_begin(ev[2]), .rx_sof_end(ev[3]),
        .tx_eof_end(ev[4]), .tx_complete(ev[5]), .rx_response_start(ev[6]),
        .mod_pulse_req(ev[7]), .protocol(protocol),
        .delayed_tx_start(delayed_tx_start), .tx_mod_pulse(tx_mod_pulse),
        .irq(irq));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task automatic check(string what, logic [15:0] exp, logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdc(logic [7:0] a, logic [7:0] exp);
        rftc_host_inst.rd(a, d);
        check("register", {8'h00, exp}, {8'h00, d});
    endtask
    task automatic pulse(int i);
        @(posedge core_clk);
        ev[i] <= 1'b1;
        @(posedge core_clk);
        ev <= 8'h00;
    endtask
    function automatic logic sig(int s);
        return s == 0 ? delayed_tx_start : s == 1 ? tx_mod_pulse : irq;
    endfunction
    task automatic count_to(int s, int lim);
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (sig(s) !== 1'b1 && n < lim);
    endtask
    task automatic t_reset;
        rdc(8'h04, 8'hc2);
        rdc(8'h05, 8'h00);
        rdc(8'h06, 8'h00);
        rdc(8'h07, 8'h0e);
        rdc(8'h20, 8'h00);
        rftc_host_inst.wr(8'h06, 8'h05);
        rdc(8'h06, 8'h05);
        @(posedge core_clk) chip_enable <= 1'b0;
        repeat (3) @(posedge core_clk);
        chip_enable <= 1'b1;
        repeat (4) @(posedge core_clk);
        rdc(8'h06, 8'h00);
    endtask
    task automatic t_proto;
        for (int i = 0; i < 3; i++) begin
            rftc_host_inst.wr(8'h05, 8'h55);
            rftc_host_inst.wr(8'h06, 8'h33);
            rftc_host_inst.wr(8'h07, 8'h22);
            rftc_host_inst.wr(8'h01, {5'h00, pc[i]});
            rdc(8'h05, 8'h00);
            rdc(8'h06, 8'h00);
            rdc(8'h07, sw[i]);
            check("protocol", {13'h0, pc[i]}, {13'h0, protocol});
        end
    endtask
    task automatic t_delay;
        rftc_host_inst.wr(8'h04, 8'hc0);
        rftc_host_inst.wr(8'h05, 8'h01);
        pulse(0);
        count_to(0, 300);
        check("wrong start event", 16'd300, 16'(n));
        pulse(3);
        count_to(0, 300);
        check("delay one step", 16'd148, 16'(n));
        rftc_host_inst.wr(8'h04, 8'h81);
        rftc_host_inst.wr(8'h05, 8'h00);
        pulse(2);
        count_to(0, 40000);
        check("delay upper bit", 16'd37888, 16'(n));
        rftc_host_inst.wr(8'h04, 8'h40);
        pulse(1);
        count_to(0, 400);
        check("delay disabled", 16'd400, 16'(n));
        rdc(8'h0c, 8'h02);
    endtask
    task automatic t_pulse;
        for (int p = 2; p < 7; p++) begin
            rftc_host_inst.wr(8'h01, 8'(p));
            if (p == 6) rftc_host_inst.wr(8'h06, 8'h02);
            pulse(7);
            count_to(1, 20);
            n = 0;
            while (tx_mod_pulse === 1'b1 && n < 3000) begin
                n++;
                @(posedge core_clk);
            end
            check("pulse width", pw[p-2], 16'(n));
        end
    endtask
    task automatic t_silence;
        rftc_host_inst.wr(8'h01, 8'h00);
        rftc_host_inst.wr(8'h07, 8'h03);
        pulse(4);
        count_to(2, 50);
        check("silence irq", 16'd13, 16'(n));
        rdc(8'h0c, 8'h01);
        check("irq cleared", 16'h0, {15'h0, irq});
        pulse(4);
        pulse(6);
        count_to(2, 30);
        check("response cancel", 16'd30, 16'(n));
        pulse(4);
        pulse(5);
        rftc_host_inst.wr(8'h00, 8'h0f);
        count_to(2, 30);
        check("fifo reset cancel", 16'd30, 16'(n));
        rftc_host_inst.wr(8'h0d, 8'h00);
        pulse(4);
        count_to(2, 30);
        check("masked irq", 16'd30, 16'(n));
        rdc(8'h0c, 8'h01);
        rftc_host_inst.wr(8'h0d, 8'h03);
        rftc_host_inst.wr(8'h01, 8'h06);
        rftc_host_inst.wr(8'h07, 8'h03);
        pulse(4);
        count_to(2, 30);
        check("other protocol", 16'd30, 16'(n));
        rdc(8'h0c, 8'h00);
    endtask
    task automatic stop_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #240000;
        miscompares++;
        stop_test;
    end
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        t_reset;
        t_proto;
        t_delay;
        t_pulse;
        t_silence;
        stop_test;
    end
endmodule
